// >>> dv/exc_seq_assertions.sv
// checker: port timing relations of the exception sequencer
`timescale 1ns/100ps
module exc_seq_assertions
    import exc_seq_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // core side inputs
    input wire logic        chip_init_pin_n,
    input wire logic        instr_done,
    input wire logic        bus_idle,
    input wire logic        cpu_addr_err,
    input wire logic [31:0] status_word,
    input wire logic [31:0] program_counter,
    input wire logic [31:0] stack_gpr,
    // memory bus and results
    input wire mem_req_s    mem_req,
    input wire logic        mem_ack,
    input wire logic        core_hold,
    input wire logic        exc_taken,
    input wire logic        load_pc,
    input wire logic        load_mask,
    input wire logic [3:0]  interrupt_mask_level,
    input wire logic [31:0] vector_base
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic [31:0] vec_idx;
    logic        rd_done;
    logic        wr_done;
    assign vec_idx = (mem_req.addr - vector_base) >> 2;
    assign rd_done = mem_req.req && mem_ack && !mem_req.write;
    assign wr_done = mem_req.req && mem_ack && mem_req.write;
    // ****************************************************************
    // reset sequence
    // ****************************************************************
    a_hold_in_reset: assert property (!chip_init_pin_n [*4] |-> core_hold)
        else $error("core not held while reset pin low");
    a_por_pair: assert property (rd_done && mem_req.addr == 32'h0000_0000
        |=> mem_req.req && !mem_req.write && mem_req.addr == 32'h0000_0004)
        else $error("power-on stack vector read missing");
    a_man_pair: assert property (rd_done && mem_req.addr == 32'h0000_0008
        |=> mem_req.req && !mem_req.write && mem_req.addr == 32'h0000_000C)
        else $error("manual stack vector read missing");
    a_reset_end: assert property (rd_done && mem_req.addr inside {32'h4, 32'hC}
        |-> ##[1:2] (load_pc && load_mask && interrupt_mask_level == 4'hF
        && vector_base == 32'h0000_0000))
        else $error("reset end without mask set and base cleared");
    // ****************************************************************
    // exception sequence
    // ****************************************************************
    a_addr_err_taken: assert property (cpu_addr_err && !core_hold |=> core_hold)
        else $error("address error not taken");
    a_first_push: assert property ($rose(mem_req.req) && mem_req.write
        |-> mem_req.addr == stack_gpr - 32'h4 && mem_req.wdata == status_word
        && $past(instr_done && bus_idle))
        else $error("status push wrong or before drain");
    a_push_order: assert property (wr_done && mem_req.addr == stack_gpr - 32'h4
        |=> mem_req.req && mem_req.write && mem_req.addr == stack_gpr - 32'h8
        && mem_req.wdata == program_counter)
        else $error("return address push wrong");
    a_vec_after_push: assert property (wr_done && mem_req.addr == stack_gpr - 32'h8
        |=> mem_req.req && !mem_req.write && mem_req.addr[1:0] == 2'h0 && vec_idx >= 32'h4)
        else $error("handler fetch missing after pushes");
    a_no_reserved: assert property (mem_req.req && !mem_req.write
        |-> !(vec_idx inside {32'h5, 32'h7, 32'h8, [32'hD:32'h1F]}) && vec_idx <= 32'hFF)
        else $error("reserved vector fetched");
    a_mask_kept: assert property (exc_taken && !load_mask
        |-> interrupt_mask_level == status_word[7:4])
        else $error("mask changed by non-interrupt");
endmodule

// >>> dv/mem_partner.sv
// memory bus partner: vector table reads and stack writes with wait states
`timescale 1ns/100ps
module mem_partner
    import exc_seq_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // bus from the sequencer
    input  wire mem_req_s    mem_req,
    input  wire logic [1:0]  slow,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    localparam logic [31:0] RD_KEY = 32'h5A00_0000;
    logic [1:0] wait_q;
    // table word is its own address scrambled; data toggles while not acked
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q    <= 2'h0;
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0000_0000;
        end else if (mem_req.req && !mem_ack && wait_q == slow) begin
            wait_q    <= 2'h0;
            mem_ack   <= 1'b1;
            mem_rdata <= mem_req.addr ^ RD_KEY;
        end else begin
            wait_q    <= (mem_req.req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// >>> dv/tb_top.sv
// testbench: exception sources, vector fetches, stack pushes and resets
`timescale 1ns/100ps
module tb_top;
    import exc_seq_pkg::*;
    localparam logic [31:0] RD_KEY    = 32'h5A00_0000;
    localparam logic [31:0] STACK_TOP = 32'h0000_0800;
    localparam logic [31:0] STAT_VAL  = 32'h0000_00A3;
    localparam logic [31:0] RET_ADDR  = 32'h0000_1234;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pin_n = 1'b0;
    logic        nmi = 1'b1;
    decode_s     decode = '0;
    logic        instr_done = 1'b1;
    logic        bus_idle = 1'b1;
    logic        ca = 1'b0;
    logic        da = 1'b0;
    logic        ir = 1'b0;
    logic [7:0]  iv = 8'h00;
    logic [3:0]  il = 4'h0;
    logic [1:0]  slow = 2'h0;
    mem_req_s    mem_req;
    logic        mem_ack, core_hold, exc_taken, load_pc, load_sp, load_mask;
    logic [31:0] mem_rdata, new_pc, new_sp, vector_base;
    logic [3:0]  mask;
    logic [64:0] bus_log[$];
    logic [35:0] rows[19];
    int          n_errors = 0;
    int          compares = 0;
    always #5 mclk = ~mclk;
    cpu_exception_sequencer dut (
        .mclk(mclk), .rst_n(rst_n), .chip_init_pin_n(pin_n), .nmi_pin(nmi),
        .decode(decode), .instr_done(instr_done), .bus_idle(bus_idle),
        .cpu_addr_err(ca), .dma_addr_err(da), .intr_req(ir), .intr_vector(iv),
        .intr_level(il), .status_word(STAT_VAL), .program_counter(RET_ADDR),
        .stack_gpr(STACK_TOP), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .core_hold(core_hold), .exc_taken(exc_taken), .load_pc(load_pc), .new_pc(new_pc),
        .load_sp(load_sp), .new_sp(new_sp), .load_mask(load_mask),
        .interrupt_mask_level(mask), .vector_base(vector_base));
    mem_partner partner (.mclk(mclk), .rst_n(rst_n), .mem_req(mem_req), .slow(slow),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    always @(posedge mclk) begin
        if (mem_ack === 1'b1 && mem_req.req === 1'b1) begin
            bus_log.push_back({mem_req.write, mem_req.addr, mem_req.wdata});
        end
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_taken();
        for (int k = 0; k < 60 && exc_taken !== 1'b1; k++) begin
            @(negedge mclk);
        end
        check("exc_taken", 32'h1, {31'h0, exc_taken});
    endtask
    task automatic do_reset(logic nmi_lvl, logic [31:0] base);
        @(negedge mclk);
        pin_n = 1'b0;
        nmi   = nmi_lvl;
        repeat (20) @(negedge mclk);
        check("held", 32'h1, {31'h0, core_hold});
        bus_log.delete();
        pin_n = 1'b1;
        wait_taken();
        check("start", base ^ RD_KEY, new_pc);
        check("stack", (base + 32'h4) ^ RD_KEY, new_sp);
        check("loads", 32'h7F, {25'h0, load_pc, load_sp, load_mask, mask});
        check("base", 32'h0, vector_base);
        check("reads", 32'h2, 32'(bus_log.size()));
    endtask
    // row: decode, addr errors and request, vector, level, expected vector
    task automatic run_row(logic [35:0] r, logic [1:0] spd, logic keep);
        logic [31:0] exp_mask;
        exp_mask = (r[20] && r[7:0] == r[19:12]) ? {28'h1, r[11:8]} : {28'h0, STAT_VAL[7:4]};
        @(negedge mclk);
        bus_log.delete();
        slow = spd;
        {decode, ca, da, ir, iv, il} = r[35:8];
        instr_done = 1'b0;
        bus_idle = 1'b0;
        for (int k = 0; k < 10 && core_hold !== 1'b1; k++) begin
            @(negedge mclk);
        end
        {ca, da, ir} = 3'h0;
        if (!keep) begin
            decode = '0;
        end
        repeat (3) @(negedge mclk);
        instr_done = 1'b1;
        repeat (2) @(negedge mclk);
        check("drain", 32'h0, {31'h0, mem_req.req});
        bus_idle = 1'b1;
        wait_taken();
        check("vec_addr", {22'h0, r[7:0], 2'h0}, bus_log[2][63:32]);
        check("handler", {22'h0, r[7:0], 2'h0} ^ RD_KEY, new_pc);
        check("new_stack", STACK_TOP - 32'h8, new_sp);
        check("push_1", STACK_TOP - 32'h4, bus_log[0][63:32]);
        check("push_1_data", STAT_VAL, bus_log[0][31:0]);
        check("push_2_data", RET_ADDR, bus_log[1][31:0]);
        check("mask", exp_mask, {27'h0, load_mask, mask});
        check("exc_loads", 32'h3, {30'h0, load_pc, load_sp});
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rows = '{{13'h1000, 3'h4, 8'h00, 4'h0, 8'h09}, {13'h1000, 3'h2, 8'h00, 4'h0, 8'h0A},
                 {13'h1120, 3'h7, 8'h40, 4'h5, 8'h09}, {13'h1000, 3'h3, 8'h40, 4'h5, 8'h0A},
                 {13'h1800, 3'h1, 8'h0B, 4'hF, 8'h0B}, {13'h1000, 3'h1, 8'h0C, 4'h3, 8'h0C},
                 {13'h1000, 3'h1, 8'h40, 4'h5, 8'h40}, {13'h1000, 3'h1, 8'h47, 4'h1, 8'h47},
                 {13'h1000, 3'h1, 8'hFF, 4'h9, 8'hFF}, {13'h1000, 3'h1, 8'h48, 4'h2, 8'h48},
                 {13'h1800, 3'h0, 8'h00, 4'h0, 8'h04}, {13'h1A00, 3'h0, 8'h00, 4'h0, 8'h06},
                 {13'h1600, 3'h0, 8'h00, 4'h0, 8'h06}, {13'h1120, 3'h0, 8'h00, 4'h0, 8'h20},
                 {13'h113F, 3'h0, 8'h00, 4'h0, 8'h3F}, {13'h1B25, 3'h0, 8'h00, 4'h0, 8'h06},
                 {13'h1920, 3'h0, 8'h00, 4'h0, 8'h04}, {13'h1105, 3'h0, 8'h00, 4'h0, 8'h25},
                 {13'h1000, 3'h2, 8'h00, 4'h0, 8'h0A}};
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        do_reset(1'b1, 32'h0000_0000);
        for (int i = 0; i < 19; i++) begin
            run_row(rows[i], 2'(i % 4), 1'b0);
        end
        run_row({13'h1800, 3'h4, 8'h00, 4'h0, 8'h09}, 2'h1, 1'b1);
        run_row(rows[10], 2'h2, 1'b0);
        do_reset(1'b0, 32'h0000_0008);
        final_report();
    end
    initial begin
        #100us;
        n_errors++;
        final_report();
    end
endmodule
bind cpu_exception_sequencer exc_seq_assertions chk (
    .mclk(mclk), .rst_n(rst_n), .chip_init_pin_n(chip_init_pin_n), .instr_done(instr_done),
    .bus_idle(bus_idle), .cpu_addr_err(cpu_addr_err), .status_word(status_word),
    .program_counter(program_counter), .stack_gpr(stack_gpr), .mem_req(mem_req),
    .mem_ack(mem_ack), .core_hold(core_hold), .exc_taken(exc_taken), .load_pc(load_pc),
    .load_mask(load_mask), .interrupt_mask_level(interrupt_mask_level),
    .vector_base(vector_base));

// >>> logic/cpu_exception_sequencer.sv
// exception acceptance, priority and vectoring for the CPU core
`timescale 1ns/100ps
// ********************************************************************
// ********************************************************************
module cpu_exception_sequencer
    import exc_seq_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // pins
    input  wire logic        chip_init_pin_n,
    input  wire logic        nmi_pin,
    // decoder and pipeline
    input  wire decode_s     decode,
    input  wire logic        instr_done,
    input  wire logic        bus_idle,
    // exception sources
    input  wire logic        cpu_addr_err,
    input  wire logic        dma_addr_err,
    input  wire logic        intr_req,
    input  wire logic [7:0]  intr_vector,
    input  wire logic [3:0]  intr_level,
    // cpu register view
    input  wire logic [31:0] status_word,
    input  wire logic [31:0] program_counter,
    input  wire logic [31:0] stack_gpr,
    // memory bus
    output mem_req_s         mem_req,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    // results to core
    output logic             core_hold,
    output logic             exc_taken,
    output logic             load_pc,
    output logic [31:0]      new_pc,
    output logic             load_sp,
    output logic [31:0]      new_sp,
    output logic             load_mask,
    output logic [3:0]       interrupt_mask_level,
    output logic [31:0]      vector_base
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0] init_sync_q;
    logic [1:0] nmi_sync_q;
    logic       init_prev_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            init_sync_q <= 2'h0;
            nmi_sync_q  <= 2'h0;
            init_prev_q <= 1'b0;
        end else begin
            init_sync_q <= {init_sync_q[0], chip_init_pin_n};
            nmi_sync_q  <= {nmi_sync_q[0], nmi_pin};
            init_prev_q <= init_sync_q[1];
        end
    end

    logic init_held;
    logic init_rise;
    assign init_held = !init_sync_q[1];
    assign init_rise = init_sync_q[1] && !init_prev_q;

    // ****************************************************************
    // vector address helpers
    // ****************************************************************
    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] num);
        vec_addr = base + {22'h000000, num, 2'h0};
    endfunction

    // ****************************************************************
    // source detection and priority
    // ****************************************************************
    src_e       src;
    logic [7:0] src_vec;

    always_comb begin
        src     = SRC_NONE;
        src_vec = VEC_ILLEGAL;
        // fixed order, higher sources first; reset handled by state machine
        if (cpu_addr_err || dma_addr_err) begin
            src     = SRC_ADDR_ERR;
            src_vec = cpu_addr_err ? VEC_CPU_ADDR_ERR : VEC_DMA_ADDR_ERR;
        end else if (intr_req && decode.valid) begin
            src     = SRC_INTR;
            src_vec = intr_vector;
        end else if (decode.valid && decode.in_delay_slot
                     && (decode.undefined || decode.writes_pc)) begin
            src     = SRC_SLOT;
            src_vec = VEC_SLOT_ILLEGAL;
        end else if (decode.valid && decode.undefined) begin
            src     = SRC_ILLEGAL;
            src_vec = VEC_ILLEGAL;
        end else if (decode.valid && decode.trap) begin
            src     = SRC_TRAP;
            // immediate folded into the user range only
            src_vec = {2'h0, 1'b1, decode.trap_imm[4:0]} | VEC_TRAP_FIRST;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    state_e      state_q,  state_d;
    src_e        cur_q,    cur_d;
    logic [7:0]  vec_q,    vec_d;
    logic        manual_q, manual_d;
    logic [31:0] sp_q,     sp_d;
    logic [31:0] pc_q,     pc_d;
    logic [31:0] sr_q,     sr_d;
    logic [3:0]  lvl_q,    lvl_d;
    logic [31:0] vbr_q,    vbr_d;
    logic [3:0]  mask_q,   mask_d;
    mem_req_s    req_q,    req_d;
    logic        hold_q,   hold_d;
    logic        taken_q,  taken_d;
    logic        ldpc_q,   ldpc_d;
    logic        ldsp_q,   ldsp_d;
    logic        ldmask_q, ldmask_d;
    logic [31:0] npc_q,    npc_d;

    always_comb begin
        state_d  = state_q;
        cur_d    = cur_q;
        vec_d    = vec_q;
        manual_d = manual_q;
        sp_d     = sp_q;
        pc_d     = pc_q;
        sr_d     = sr_q;
        lvl_d    = lvl_q;
        vbr_d    = vbr_q;
        mask_d   = mask_q;
        req_d    = req_q;
        hold_d   = hold_q;
        taken_d  = 1'b0;
        ldpc_d   = 1'b0;
        ldsp_d   = 1'b0;
        ldmask_d = 1'b0;
        npc_d    = npc_q;
        if (init_held) begin
            state_d = ST_RUN;
            req_d   = '0;
            hold_d  = 1'b1;
        end else if (init_rise) begin
            manual_d    = !nmi_sync_q[1];
            state_d     = ST_RST_PC;
            hold_d      = 1'b1;
            req_d       = '0;
            req_d.req   = 1'b1;
            // no base added for resets
            req_d.addr  = vec_addr(VBR_RESET_VAL, nmi_sync_q[1] ? VEC_POR_PC : VEC_MAN_PC);
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    hold_d = 1'b0;
                    if (src != SRC_NONE) begin
                        cur_d   = src;
                        vec_d   = src_vec;
                        lvl_d   = intr_level;
                        hold_d  = 1'b1;
                        state_d = ST_WAIT_DRAIN;
                    end
                end
                ST_RST_PC: if (mem_ack) begin
                    npc_d      = mem_rdata;
                    req_d.addr = vec_addr(VBR_RESET_VAL, manual_q ? VEC_MAN_SP : VEC_POR_SP);
                    state_d    = ST_RST_SP;
                end
                ST_RST_SP: if (mem_ack) begin
                    sp_d      = mem_rdata;
                    req_d.req = 1'b0;
                    state_d   = ST_RST_DONE;
                end
                ST_RST_DONE: begin
                    vbr_d    = VBR_RESET_VAL;
                    mask_d   = MASK_RESET_VAL;
                    ldmask_d = 1'b1;
                    ldsp_d   = 1'b1;
                    ldpc_d   = 1'b1;
                    taken_d  = 1'b1;
                    hold_d   = 1'b0;
                    state_d  = ST_RUN;
                end
                ST_WAIT_DRAIN: if (instr_done && bus_idle) begin
                    sr_d        = status_word;
                    pc_d        = program_counter;
                    sp_d        = stack_gpr - WORD_BYTES;
                    req_d.req   = 1'b1;
                    req_d.write = 1'b1;
                    req_d.addr  = stack_gpr - WORD_BYTES;
                    req_d.wdata = status_word;
                    state_d     = ST_PUSH_SR;
                end
                ST_PUSH_SR: if (mem_ack) begin
                    sp_d        = sp_q - WORD_BYTES;
                    req_d.addr  = sp_q - WORD_BYTES;
                    req_d.wdata = pc_q;
                    state_d     = ST_PUSH_PC;
                end
                ST_PUSH_PC: if (mem_ack) begin
                    req_d.write = 1'b0;
                    req_d.wdata = '0;
                    req_d.addr  = vec_addr(vbr_q, vec_q);
                    state_d     = ST_VEC_RD;
                end
                ST_VEC_RD: if (mem_ack) begin
                    npc_d     = mem_rdata;
                    req_d.req = 1'b0;
                    state_d   = ST_BRANCH;
                end
                ST_BRANCH: begin
                    if (cur_q == SRC_INTR) begin
                        mask_d   = lvl_q;
                        ldmask_d = 1'b1;
                    end else begin
                        mask_d   = status_word[MASK_LSB +: MASK_W];
                    end
                    ldsp_d  = 1'b1;
                    ldpc_d  = 1'b1; // not delayed
                    taken_d = 1'b1;
                    hold_d  = 1'b0;
                    state_d = ST_RUN;
                end
                default: state_d = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= ST_RUN;
            cur_q    <= SRC_NONE;
            vec_q    <= 8'h00;
            manual_q <= 1'b0;
            sp_q     <= 32'h0000_0000;
            pc_q     <= 32'h0000_0000;
            sr_q     <= 32'h0000_0000;
            lvl_q    <= 4'h0;
            vbr_q    <= VBR_RESET_VAL;
            mask_q   <= MASK_RESET_VAL;
            req_q    <= '0;
            hold_q   <= 1'b1;
            taken_q  <= 1'b0;
            ldpc_q   <= 1'b0;
            ldsp_q   <= 1'b0;
            ldmask_q <= 1'b0;
            npc_q    <= 32'h0000_0000;
        end else begin
            state_q  <= state_d;
            cur_q    <= cur_d;
            vec_q    <= vec_d;
            manual_q <= manual_d;
            sp_q     <= sp_d;
            pc_q     <= pc_d;
            sr_q     <= sr_d;
            lvl_q    <= lvl_d;
            vbr_q    <= vbr_d;
            mask_q   <= mask_d;
            req_q    <= req_d;
            hold_q   <= hold_d;
            taken_q  <= taken_d;
            ldpc_q   <= ldpc_d;
            ldsp_q   <= ldsp_d;
            ldmask_q <= ldmask_d;
            npc_q    <= npc_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign mem_req              = req_q;
    assign core_hold            = hold_q;
    assign exc_taken            = taken_q;
    assign load_pc              = ldpc_q;
    assign new_pc               = npc_q;
    assign load_sp              = ldsp_q;
    assign new_sp               = sp_q;
    assign load_mask            = ldmask_q;
    assign interrupt_mask_level = mask_q;
    assign vector_base          = vbr_q;

endmodule

// >>> logic/exc_seq_pkg.sv
// package: constants, types and enums for the exception sequencer
package exc_seq_pkg;

    // ****************************************************************
    // vector numbers
    // ****************************************************************
    localparam logic [7:0] VEC_POR_PC       = 8'h00;
    localparam logic [7:0] VEC_POR_SP       = 8'h01;
    localparam logic [7:0] VEC_MAN_PC       = 8'h02;
    localparam logic [7:0] VEC_MAN_SP       = 8'h03;
    localparam logic [7:0] VEC_ILLEGAL      = 8'h04;
    localparam logic [7:0] VEC_SLOT_ILLEGAL = 8'h06;
    localparam logic [7:0] VEC_CPU_ADDR_ERR = 8'h09;
    localparam logic [7:0] VEC_DMA_ADDR_ERR = 8'h0A;
    localparam logic [7:0] VEC_NMI          = 8'h0B;
    localparam logic [7:0] VEC_USER_BREAK   = 8'h0C;
    localparam logic [7:0] VEC_TRAP_FIRST   = 8'h20;
    localparam logic [7:0] VEC_TRAP_LAST    = 8'h3F;
    localparam logic [7:0] VEC_EXT_REQ0     = 8'h40;
    localparam logic [7:0] VEC_PERIPH_FIRST = 8'h48;

    // ****************************************************************
    // status word fields and reset values
    // ****************************************************************
    localparam int          MASK_LSB       = 4;
    localparam int          MASK_W         = 4;
    localparam logic [3:0]  MASK_RESET_VAL = 4'hF;
    localparam logic [31:0] VBR_RESET_VAL  = 32'h0000_0000;
    localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_ADDR_ERR,
        SRC_INTR,
        SRC_TRAP,
        SRC_ILLEGAL,
        SRC_SLOT
    } src_e;

    typedef enum logic [3:0] {
        ST_RUN,
        ST_RST_PC,
        ST_RST_SP,
        ST_RST_DONE,
        ST_WAIT_DRAIN,
        ST_PUSH_SR,
        ST_PUSH_PC,
        ST_VEC_RD,
        ST_BRANCH
    } state_e;

    // decoder view of the current instruction
    typedef struct packed {
        logic       valid;
        logic       undefined;
        logic       writes_pc;
        logic       in_delay_slot;
        logic       trap;
        logic [7:0] trap_imm;
    } decode_s;

    // memory bus request from the sequencer
    typedef struct packed {
        logic        req;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_s;

endpackage
